// ---- hdl/atc_link.sv ----
// Purpose: powertrain end of the cruise axle torque command and status exchange
// Assumes: one frame per cmd_valid pulse; rc_err flags that frame's rolling count
// Notes: protection word is valid when it equals the bitwise inverse of the packet
//
// Function
// - act on accepted command within 50 ms
// - check 25-bit protection word per command
// - failed check keeps last accepted command
// - x-of-y window counts rolling and protection errors
// - send 5-bit status: request and limiting
// - code 0: cruise inactive, ignore torque
// - code 1: request honored, limits possible
// - code 2: arbitration lost, direction not encoded
// - code 3: denied, ignore all torque requests
// - transmission disengage reported as denied
// - code 4: suspended until driver input
// - limiting codes none, min, max, rate
// - limiting not limited unless honored
// - comm failure denies until clean recovery time
// - ignore torque while active flag false
`timescale 1ns/100ps
module atc_link
  import atc_pkg::*;
#(
  parameter int MS_CYCLES = ATC_MS_CYC,
  parameter int ACT_DELAY_CYC = ATC_ACT_DELAY_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic cmd_valid,
  input wire atc_cmd_t cmd_frame,
  input wire logic prot_valid,
  input wire logic [24:0] cmd_prot,
  input wire logic rc_err,
  input wire logic arb_lost,
  input wire logic ecu_deny,
  input wire logic tcu_deny,
  input wire logic accel_apply,
  input wire logic resume_apply,
  input wire logic [1:0] lim_req,
  output atc_status_t status,
  output logic torque_en,
  output logic [18:0] torque_req,
  output logic set_only_reengage
);

  typedef struct packed {
    atc_cmd_t cmd;
    logic [ATC_HIST_LEN-1:0] hist;
    logic [4:0] err_cnt;
    logic comm_fail;
    logic [15:0] ms_div;
    logic [13:0] clean_ms;
    logic [13:0] silent_ms;
    logic suspend;
    atc_status_t stat;
    logic torque_en;
    logic [18:0] torque;
    logic reeng;
    logic en;
    logic [4:0] x_thr;
    logic [13:0] recov_ms;
    logic [13:0] tmo_ms;
    logic ack;
    logic [31:0] rdat;
  } atc_state_t;

  atc_state_t state_q;
  atc_state_t state_d;

  logic prot_ok;
  logic frame_err;
  logic accept;
  logic tick;
  logic timeout;
  logic fault;
  logic wr;
  logic [31:0] wval;

  // byte-lane merge of a write onto the old register image
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // frame checks and event terms
  always_comb begin
    prot_ok = prot_valid && (cmd_prot == ~cmd_frame);
    frame_err = rc_err || !prot_ok;
    accept = cmd_valid && !frame_err && state_q.en;
    tick = (state_q.ms_div == 16'(MS_CYCLES - 1));
    timeout = (state_q.silent_ms >= state_q.tmo_ms);
    fault = (state_q.err_cnt >= state_q.x_thr) || timeout || (cmd_valid && frame_err);
    wr = wb_cyc && wb_stb && wb_we && !state_q.ack;
  end

  // next-state logic
  always_comb begin
    state_d = state_q;
    state_d.ack = 1'b0;
    wval = 32'h00000000;

    // command store: a rejected frame leaves the last good one in place
    if (accept) begin
      state_d.cmd = cmd_frame;
    end

    // sliding error window over the last frames
    if (cmd_valid) begin
      state_d.hist = {state_q.hist[ATC_HIST_LEN-2:0], frame_err};
      state_d.err_cnt = 5'(state_q.err_cnt + {4'h0, frame_err} -
                           {4'h0, state_q.hist[ATC_HIST_LEN-1]});
    end

    // millisecond time base
    state_d.ms_div = tick ? 16'h0000 : 16'(state_q.ms_div + 16'h0001);

    // missing-frame watchdog
    if (cmd_valid) begin
      state_d.silent_ms = 14'h0000;
    end else if (tick && state_q.silent_ms != 14'h3FFF) begin
      state_d.silent_ms = 14'(state_q.silent_ms + 14'h0001);
    end

    // failure latch and clean-run recovery; a new fault wins over recovery
    if (fault) begin
      state_d.clean_ms = 14'h0000;
      state_d.comm_fail = 1'b1;
    end else begin
      if (tick && state_q.clean_ms != 14'h3FFF) begin
        state_d.clean_ms = 14'(state_q.clean_ms + 14'h0001);
      end
      if (state_q.clean_ms >= state_q.recov_ms) begin
        state_d.comm_fail = 1'b0;
      end
    end

    // stopped-vehicle suspension, released by the needed driver input
    if (accept && cmd_frame.go_state == ATC_GO_NOT_STOPPED) begin
      state_d.suspend = 1'b0;
    end else if (accept && state_q.cmd.go_state == ATC_GO_NOT_STOPPED) begin
      state_d.suspend = 1'b1;
    end else if (state_q.cmd.go_state == ATC_GO_PEDAL && accel_apply) begin
      state_d.suspend = 1'b0;
    end else if (state_q.cmd.go_state == ATC_GO_PEDAL_RESUME &&
                 (accel_apply || resume_apply)) begin
      state_d.suspend = 1'b0;
    end

    // request status in priority order; only codes 0..4 are produced
    if (!state_q.en || state_q.comm_fail || ecu_deny || tcu_deny) begin
      state_d.stat.req = ATC_REQ_DENIED;
    end else if (!state_q.cmd.active ||
                 (state_q.cmd.cruise_type != ATC_TYPE_ADAPTIVE &&
                  state_q.cmd.cruise_type != ATC_TYPE_FULL_RANGE)) begin
      state_d.stat.req = ATC_REQ_NONE;
    end else if (state_q.suspend) begin
      state_d.stat.req = ATC_REQ_SUSPENDED;
    end else if (arb_lost) begin
      state_d.stat.req = ATC_REQ_LOST_ARB;
    end else begin
      state_d.stat.req = ATC_REQ_HONORED;
    end

    // limiting feedback only while honored
    if (state_d.stat.req == ATC_REQ_HONORED) begin
      state_d.stat.lim = lim_req;
    end else begin
      state_d.stat.lim = ATC_LIM_NONE;
    end

    // torque handed to arbitration only while honored
    state_d.torque_en = (state_d.stat.req == ATC_REQ_HONORED);
    state_d.torque = state_d.torque_en ? state_q.cmd.torque : 19'h00000;
    state_d.reeng = state_q.cmd.reengage_set_only;

    // register writes
    if (wr) begin
      if (wb_adr[7:2] == ATC_OFS_CTRL[7:2]) begin
        wval = wmerge({19'h00000, state_q.x_thr, 7'h00, state_q.en}, wb_dat_w, wb_sel);
        state_d.en = wval[ATC_CTRL_EN_BIT];
        state_d.x_thr = wval[ATC_CTRL_XTHR_LSB +: 5];
        if (state_d.x_thr == 5'h00) begin
          state_d.x_thr = 5'h01;
        end
      end else if (wb_adr[7:2] == ATC_OFS_RECOV[7:2]) begin
        wval = wmerge({18'h00000, state_q.recov_ms}, wb_dat_w, wb_sel);
        if (wval[31:14] != 18'h00000 || wval[13:0] > ATC_RECOV_MAX_MS) begin
          state_d.recov_ms = ATC_RECOV_MAX_MS;
        end else if (wval[13:0] < ATC_RECOV_MIN_MS) begin
          state_d.recov_ms = ATC_RECOV_MIN_MS;
        end else begin
          state_d.recov_ms = wval[13:0];
        end
      end else if (wb_adr[7:2] == ATC_OFS_TMO[7:2]) begin
        wval = wmerge({18'h00000, state_q.tmo_ms}, wb_dat_w, wb_sel);
        state_d.tmo_ms = (wval[13:0] == 14'h0000) ? 14'h0001 : wval[13:0];
      end
    end

    // read data and single-cycle acknowledge
    if (wb_cyc && wb_stb && !state_q.ack) begin
      state_d.ack = 1'b1;
      if (wb_adr[7:2] == ATC_OFS_CTRL[7:2]) begin
        state_d.rdat = {19'h00000, state_q.x_thr, 7'h00, state_q.en};
      end else if (wb_adr[7:2] == ATC_OFS_RECOV[7:2]) begin
        state_d.rdat = {18'h00000, state_q.recov_ms};
      end else if (wb_adr[7:2] == ATC_OFS_TMO[7:2]) begin
        state_d.rdat = {18'h00000, state_q.tmo_ms};
      end else if (wb_adr[7:2] == ATC_OFS_STAT[7:2]) begin
        state_d.rdat = 32'h00000000;
        state_d.rdat[2:0] = state_q.stat.req;
        state_d.rdat[ATC_STAT_LIM_LSB +: 2] = state_q.stat.lim;
        state_d.rdat[ATC_STAT_FAIL_BIT] = state_q.comm_fail;
        state_d.rdat[ATC_STAT_SUSP_BIT] = state_q.suspend;
        state_d.rdat[ATC_STAT_CNT_LSB +: 5] = state_q.err_cnt;
      end else if (wb_adr[7:2] == ATC_OFS_LAST[7:2]) begin
        state_d.rdat = {7'h00, state_q.cmd};
      end else begin
        state_d.rdat = 32'h00000000;
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= '0;
      state_q.cmd <= ATC_CMD_RST;
      state_q.comm_fail <= 1'b1;
      state_q.stat.req <= ATC_REQ_DENIED;
      state_q.en <= 1'b1;
      state_q.x_thr <= ATC_XTHR_DEF;
      state_q.recov_ms <= ATC_RECOV_MIN_MS;
      state_q.tmo_ms <= ATC_TMO_DEF_MS;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state register
  assign wb_dat_r = state_q.rdat;
  assign wb_ack = state_q.ack;
  assign status = state_q.stat;
  assign torque_en = state_q.torque_en;
  assign torque_req = state_q.torque;
  assign set_only_reengage = state_q.reeng;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  initial begin
    a_act_budget: assert (ATC_ACT_LAT < ACT_DELAY_CYC) else $error("latency over budget");
  end

  a_act_delay: assert property (accept |-> ##2
    (!torque_en || torque_req == $past(cmd_frame.torque, 2)))
    else $error("accepted torque not applied in time");

  a_prot_keeps: assert property (cmd_valid && !prot_ok |=> state_q.cmd == $past(state_q.cmd))
    else $error("bad protection word changed command");

  a_accept_loads: assert property (accept |=> state_q.cmd == $past(cmd_frame))
    else $error("good command not stored");

  a_window_fault: assert property (state_q.err_cnt >= state_q.x_thr |=> state_q.comm_fail)
    else $error("error window did not latch failure");

  a_fail_denied: assert property (state_q.comm_fail |=> status.req == ATC_REQ_DENIED)
    else $error("failure not reported as denied");

  a_tcu_denied: assert property (tcu_deny |=> status.req == ATC_REQ_DENIED)
    else $error("transmission disengage not denied");

  a_torque_gate: assert property (torque_en == (status.req == ATC_REQ_HONORED))
    else $error("torque passed while not honored");

  a_lim_honored: assert property (status.req != ATC_REQ_HONORED |->
    status.lim == ATC_LIM_NONE)
    else $error("limit shown while not honored");

  a_code_range: assert property (status.req <= ATC_REQ_SUSPENDED)
    else $error("unused request code sent");

  a_inactive_none: assert property (state_q.en && !state_q.comm_fail && !ecu_deny &&
    !tcu_deny && !state_q.cmd.active |=> status.req == ATC_REQ_NONE && !torque_en)
    else $error("inactive command not ignored");

  c_accept: cover property (accept ##2 torque_en);
  c_prot_fail: cover property (cmd_valid && !prot_ok);
  c_recover: cover property (state_q.comm_fail ##1 !state_q.comm_fail);
  c_lost_arb: cover property (status.req == ATC_REQ_LOST_ARB);
  c_resume: cover property (state_q.suspend ##1 !state_q.suspend);

endmodule : atc_link

// ---- hdl/atc_pkg.sv ----
// Purpose: shared constants and carriers for the axle torque command/status link
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register slave
// Notes: command packet and protection word are both 25 bits wide
package atc_pkg;

  // clock and time base
  localparam int ATC_CLK_HZ = 40_000_000;
  localparam int ATC_TICK_MS = 1;
  localparam int ATC_MS_CYC = ATC_CLK_HZ / 1000 * ATC_TICK_MS;
  localparam int ATC_ACT_DELAY_MS = 50;
  localparam int ATC_ACT_DELAY_CYC = ATC_CLK_HZ / 1000 * ATC_ACT_DELAY_MS;
  localparam int ATC_ACT_LAT = 2; // accepted frame to torque output, in cycles

  // recovery and timeout limits and defaults in milliseconds, error window settings in frames
  localparam logic [13:0] ATC_RECOV_MIN_MS = 14'h03E8;
  localparam logic [13:0] ATC_RECOV_MAX_MS = 14'h2710;
  localparam logic [13:0] ATC_TMO_DEF_MS = 14'h0064;
  localparam logic [4:0] ATC_XTHR_DEF = 5'h04;
  localparam int ATC_HIST_LEN = 16;

  // register byte offsets
  localparam logic [7:0] ATC_OFS_CTRL = 8'h00;
  localparam logic [7:0] ATC_OFS_RECOV = 8'h04;
  localparam logic [7:0] ATC_OFS_TMO = 8'h08;
  localparam logic [7:0] ATC_OFS_STAT = 8'h0C;
  localparam logic [7:0] ATC_OFS_LAST = 8'h10;

  // field positions
  localparam int ATC_CTRL_EN_BIT = 0;
  localparam int ATC_CTRL_XTHR_LSB = 8;
  localparam int ATC_STAT_LIM_LSB = 3;
  localparam int ATC_STAT_FAIL_BIT = 8;
  localparam int ATC_STAT_SUSP_BIT = 9;
  localparam int ATC_STAT_CNT_LSB = 16;

  // request status codes
  localparam logic [2:0] ATC_REQ_NONE = 3'h0;
  localparam logic [2:0] ATC_REQ_HONORED = 3'h1;
  localparam logic [2:0] ATC_REQ_LOST_ARB = 3'h2;
  localparam logic [2:0] ATC_REQ_DENIED = 3'h3;
  localparam logic [2:0] ATC_REQ_SUSPENDED = 3'h4;

  // limiting status codes
  localparam logic [1:0] ATC_LIM_NONE = 2'h0;
  localparam logic [1:0] ATC_LIM_MIN = 2'h1;
  localparam logic [1:0] ATC_LIM_MAX = 2'h2;
  localparam logic [1:0] ATC_LIM_RATE = 2'h3;

  // cruise type and go-state codes
  localparam logic [1:0] ATC_TYPE_ADAPTIVE = 2'h0;
  localparam logic [1:0] ATC_TYPE_FULL_RANGE = 2'h1;
  localparam logic [1:0] ATC_GO_NOT_STOPPED = 2'h0;
  localparam logic [1:0] ATC_GO_PEDAL = 2'h1;
  localparam logic [1:0] ATC_GO_PEDAL_RESUME = 2'h2;

  // received command packet, msb first
  typedef struct packed {
    logic active;
    logic [1:0] cruise_type;
    logic [1:0] go_state;
    logic reengage_set_only;
    logic [18:0] torque;
  } atc_cmd_t;

  // transmitted status packet
  typedef struct packed {
    logic [2:0] req;
    logic [1:0] lim;
  } atc_status_t;

  localparam atc_cmd_t ATC_CMD_RST = 25'h0000000;

endpackage : atc_pkg

// ---- verif/atc_acr_model.sv ----
// Purpose: cruise requester model that sends command frames on a fixed period
// Assumes: one frame every PERIOD cycles; a good protection word is the inverted packet
// Notes: between frames the lines toggle so stale data never looks valid
`timescale 1ns/100ps
module atc_acr_model
  import atc_pkg::*;
#(
  parameter int PERIOD = 20
) (
  input wire logic clk_sys,
  output logic cmd_valid,
  output atc_cmd_t cmd_frame,
  output logic prot_valid,
  output logic [24:0] cmd_prot,
  output logic rc_err
);
  atc_cmd_t nxt = ATC_CMD_RST;
  int cnt = 0;
  int inj_q = 0;
  int inj_d = 0;
  logic inj_rc = 1'h0;
  // quiet lines at time zero
  initial begin
    cmd_valid = 1'h0;
    cmd_frame = ATC_CMD_RST;
    prot_valid = 1'h0;
    cmd_prot = 25'h1FFFFFF;
    rc_err = 1'h0;
  end
  // content of every following frame
  task load(input atc_cmd_t f);
    nxt = f;
  endtask : load
  // spoil the next frame: rolling count when rc, protection word otherwise
  task inject(input logic rc);
    inj_rc = rc;
    inj_q++;
  endtask : inject
  // periodic sender
  always @(posedge clk_sys) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    if (cnt == PERIOD - 1) begin
      cmd_valid <= 1'h1;
      cmd_frame <= nxt;
      prot_valid <= 1'h1;
      cmd_prot <= (inj_q != inj_d && !inj_rc) ? nxt : ~nxt;
      rc_err <= inj_q != inj_d && inj_rc;
      inj_d <= inj_q;
    end else begin
      cmd_valid <= 1'h0;
      cmd_frame <= ~cmd_frame;
      prot_valid <= 1'h0;
      cmd_prot <= ~cmd_prot;
      rc_err <= 1'h0;
    end
  end
endmodule : atc_acr_model

// ---- verif/atc_link_tb.sv ----
// Purpose: self-checking bench for the torque command and status link
// Assumes: 1 ms tick cut to 10 cycles, requester frames every 20 cycles
// Notes: after reset no request is honored until 1000 clean ticks have passed
`timescale 1ns/100ps
module atc_link_tb;
  import atc_pkg::*;
  localparam logic [18:0] TQ1 = 19'h2AF31;
  localparam logic [18:0] TQ2 = 19'h15A0C;
  logic clk_sys = 1'h0, reset_n = 1'h0;
  logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  logic wb_ack, cmd_valid, prot_valid, rc_err, torque_en, set_only_reengage;
  atc_cmd_t cmd_frame;
  logic [24:0] cmd_prot;
  logic arb_lost = 1'h0, ecu_deny = 1'h0, tcu_deny = 1'h0;
  logic accel_apply = 1'h0, resume_apply = 1'h0;
  logic [1:0] lim_req = 2'h0;
  atc_status_t status;
  logic [18:0] torque_req;
  int err_count = 0, n_compared = 0;
  atc_link #(.MS_CYCLES(10)) atc_link_inst (.clk_sys, .reset_n, .wb_cyc, .wb_stb,
    .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .cmd_valid, .cmd_frame,
    .prot_valid, .cmd_prot, .rc_err, .arb_lost, .ecu_deny, .tcu_deny, .accel_apply,
    .resume_apply, .lim_req, .status, .torque_en, .torque_req, .set_only_reengage);
  atc_acr_model atc_acr_model_inst (.clk_sys, .cmd_valid, .cmd_frame, .prot_valid,
    .cmd_prot, .rc_err);
  // 25 ns clock
  always #12.5 clk_sys = ~clk_sys;
  task miss(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : miss
  // word compare
  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) miss($sformatf("word %h want %h", got, exp));
  endtask : cmp32
  // status compare once inputs have settled
  task chk_st(input logic [2:0] req, input logic [1:0] lim);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    n_compared++;
    if (status !== {req, lim} || torque_en !== (req == ATC_REQ_HONORED))
      miss($sformatf("status %h want %h", status, {req, lim}));
  endtask : chk_st
  // one classic cycle, request held until ack is sampled
  task wb_io(input logic we, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= wd;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'h1 && n < 20);
    if (n == 20) miss("no ack");
    rd = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clk_sys);
  endtask : wb_io
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    wb_io(1'h0, a, 32'h0, d);
    cmp32(d, e);
  endtask : rd_chk
  // adaptive type, re-engage flag false
  function automatic atc_cmd_t mk(input logic act, input logic [1:0] go,
      input logic [18:0] tq);
    mk = '{act, ATC_TYPE_ADAPTIVE, go, 1'h0, tq};
  endfunction : mk
  // wait until the requester sends this frame
  task frame(input atc_cmd_t f);
    int n;
    atc_acr_model_inst.load(f);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (!(cmd_valid === 1'h1 && cmd_frame === f) && n < 100);
    if (n == 100) miss("frame not sent");
  endtask : frame
  // status code stays within the defined set
  always @(negedge clk_sys) begin
    if (reset_n === 1'h1 && status.req > ATC_REQ_SUSPENDED) miss("unused code");
  end
  task t_reset;
    logic [31:0] d;
    chk_st(ATC_REQ_DENIED, ATC_LIM_NONE);
    rd_chk(ATC_OFS_CTRL, 32'h0000_0401);
    wb_io(1'h1, ATC_OFS_CTRL, 32'h0000_0000, d);
    rd_chk(ATC_OFS_CTRL, 32'h0000_0100);
    wb_io(1'h1, ATC_OFS_CTRL, 32'h0000_0401, d);
    rd_chk(ATC_OFS_TMO, 32'h0000_0064);
    rd_chk(ATC_OFS_STAT, 32'h0000_0103);
    rd_chk(8'h40, 32'h0);
    wb_io(1'h1, ATC_OFS_RECOV, 32'h0000_01F4, d);
    rd_chk(ATC_OFS_RECOV, 32'h0000_03E8);
    $display("test reset done");
  endtask : t_reset
  task t_recover;
    int n;
    frame(mk(1'h1, ATC_GO_NOT_STOPPED, TQ1));
    repeat (4000) @(posedge clk_sys);
    chk_st(ATC_REQ_DENIED, ATC_LIM_NONE);
    n = 0;
    while (status.req !== ATC_REQ_HONORED && n < 8000) begin
      @(negedge clk_sys);
      n++;
    end
    chk_st(ATC_REQ_HONORED, ATC_LIM_NONE);
    cmp32(32'(torque_req), 32'(TQ1));
    $display("test recover done");
  endtask : t_recover
  // limits, arbitration and deny, lim_req left at rate
  task t_status;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      lim_req <= 2'(i);
      chk_st(ATC_REQ_HONORED, 2'(i));
    end
    @(posedge clk_sys);
    arb_lost <= 1'h1;
    chk_st(ATC_REQ_LOST_ARB, ATC_LIM_NONE);
    cmp32(32'(torque_req), 32'h0);
    @(posedge clk_sys);
    arb_lost <= 1'h0;
    ecu_deny <= 1'h1;
    chk_st(ATC_REQ_DENIED, ATC_LIM_NONE);
    cmp32(32'(torque_req), 32'h0);
    @(posedge clk_sys);
    ecu_deny <= 1'h0;
    tcu_deny <= 1'h1;
    chk_st(ATC_REQ_DENIED, ATC_LIM_NONE);
    @(posedge clk_sys);
    tcu_deny <= 1'h0;
    frame(mk(1'h0, ATC_GO_NOT_STOPPED, TQ2));
    chk_st(ATC_REQ_NONE, ATC_LIM_NONE);
    cmp32(32'(torque_req), 32'h0);
    frame('{1'h1, 2'h2, ATC_GO_NOT_STOPPED, 1'h0, TQ2});
    chk_st(ATC_REQ_NONE, ATC_LIM_NONE);
    frame(mk(1'h1, ATC_GO_NOT_STOPPED, TQ2));
    chk_st(ATC_REQ_HONORED, ATC_LIM_RATE);
    cmp32(32'(torque_req), 32'(TQ2));
    $display("test status done");
  endtask : t_status
  task t_suspend;
    frame(mk(1'h1, ATC_GO_PEDAL, TQ2));
    chk_st(ATC_REQ_SUSPENDED, ATC_LIM_NONE);
    @(posedge clk_sys);
    resume_apply <= 1'h1;
    chk_st(ATC_REQ_SUSPENDED, ATC_LIM_NONE);
    @(posedge clk_sys);
    accel_apply <= 1'h1;
    chk_st(ATC_REQ_HONORED, ATC_LIM_RATE);
    @(posedge clk_sys);
    accel_apply <= 1'h0;
    resume_apply <= 1'h0;
    frame(mk(1'h1, ATC_GO_NOT_STOPPED, TQ2));
    frame(mk(1'h1, ATC_GO_PEDAL_RESUME, TQ2));
    chk_st(ATC_REQ_SUSPENDED, ATC_LIM_NONE);
    @(posedge clk_sys);
    resume_apply <= 1'h1;
    chk_st(ATC_REQ_HONORED, ATC_LIM_RATE);
    @(posedge clk_sys);
    resume_apply <= 1'h0;
    // full-range requester asking for set-switch re-engagement
    frame('{1'h1, ATC_TYPE_FULL_RANGE, ATC_GO_NOT_STOPPED, 1'h1, TQ1});
    chk_st(ATC_REQ_HONORED, ATC_LIM_RATE);
    cmp32(32'(set_only_reengage), 32'h1);
    frame(mk(1'h1, ATC_GO_NOT_STOPPED, TQ1));
    chk_st(ATC_REQ_HONORED, ATC_LIM_RATE);
    cmp32(32'(set_only_reengage), 32'h0);
    $display("test suspend done");
  endtask : t_suspend
  // bad frames are dropped and counted in the window
  task t_bad;
    logic [31:0] d;
    // threshold of two, so the second bad frame trips the window
    wb_io(1'h1, ATC_OFS_CTRL, 32'h0000_0201, d);
    rd_chk(ATC_OFS_CTRL, 32'h0000_0201);
    for (int i = 0; i < 2; i++) begin
      atc_acr_model_inst.inject(1'(i));
      frame(mk(1'h1, ATC_GO_NOT_STOPPED, TQ2));
      atc_acr_model_inst.load(mk(1'h1, ATC_GO_NOT_STOPPED, TQ1));
      chk_st(ATC_REQ_DENIED, ATC_LIM_NONE);
      rd_chk(ATC_OFS_LAST, 32'(mk(1'h1, ATC_GO_NOT_STOPPED, TQ1)));
      rd_chk(ATC_OFS_STAT, 32'h0000_0103 + 32'((i + 1) << 16));
    end
    $display("test bad frame done");
  endtask : t_bad
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_reset;
    t_recover;
    t_status;
    t_suspend;
    t_bad;
    report_and_stop;
  end
  // watchdog, about four times the expected run
  initial begin
    #(40000 * 25);
    miss("watchdog expired");
    report_and_stop;
  end
endmodule : atc_link_tb
